//--- core/afmd_top.v
// Task-file command interpreter for feature, block-count and diagnostic commands
//
// Summary of operation
// R1: Transfer subcode: count is type[7:3], mode[2:0]
// R2: Accept 0x00 and PIO flow modes 0x08-0x0C
// R3: Accept multiword DMA modes 0x20-0x22
// R4: Accept Ultra DMA modes 0x40-0x45
// R5: Other transfer-mode values abort the command
// R6: PIO 4 and MW DMA 2 usable by default; reset loads mode 0x0C (PIO 4) only
// R7: Subcode 0x42 enables acoustic level from count
// R8: Classify acoustic levels by range
// R9: Acoustic state survives every kind of reset
// R10: Subcode 0xC2 disables; identify bits read zero
// R11: Block counts 2, 4, 8, 16 supported
// R12: Block-count command: busy, check, store, enable
// R13: Bad count aborts; zero accepted; both disable
// R14: Block-count end: drop busy, raise interrupt
// R15: Hard reset disables multiple; soft reset keeps
// R16: Identify word 47 reads 0x8010
// R17: Word 59 zero or 0x01 plus count
// R18: Diagnostic runs regardless of device select
// R19: Device 0 waits five seconds for PDIAG-
// R20: Device 1 failure merges 0x80 into code
// R21: Device 0 interrupts; device 1 stays silent
// R22: Host may select device 1 for status
// R23: Feature command: busy, capture, interrupt, abort bad
// R24: Diagnostic code in error register
`timescale 1ns/1ns
`include "afmd_map.vh"

module afmd_top #(
  parameter [31:0] D1_WAIT_CYC = `AFMD_D1_WAIT_S * `AFMD_CLK_HZ
) (
  input  wire        clock,
  input  wire        reset,
  input  wire [13:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [13:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        pdiag_n_in,
  output wire        pdiag_n_out,
  output wire        pdiag_n_oe_n,
  output reg         intrq
);

  // --------------------------------
  // State
  // --------------------------------
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_EXEC = 2'h1;
  localparam [1:0] S_DIAG = 2'h2;
  localparam [1:0] S_WAIT = 2'h3;

  reg  [1:0]  state_r;
  reg  [7:0]  opcode_reg_r;
  reg  [7:0]  subcode_reg_r;
  reg  [7:0]  count_reg_r;
  reg  [7:0]  sector_index_reg_r;
  reg  [7:0]  cyl_low_r;
  reg  [7:0]  cyl_high_r;
  reg  [7:0]  drive_head_select_r;
  reg  [7:0]  fault_code_reg_r;
  reg         bsy_r;
  reg         err_r;
  reg  [4:0]  ctrl_r;
  reg  [7:0]  xfer_mode_r;
  reg         mult_en_r;
  reg  [7:0]  mult_cnt_r;
  reg         pdiag_drive_r;
  reg  [31:0] wait_r;
  reg  [7:0]  diag_code_r;

  // Kept out of the reset path on purpose: acoustic state outlives all resets
  reg         aam_en_r;
  reg  [7:0]  aam_level_r;
  initial begin
    aam_en_r    = 1'b0;
    aam_level_r = 8'h00;
  end

  wire        st_done;
  wire [7:0]  st_code;
  wire        xfer_ok;
  wire [1:0]  aam_class;
  reg         st_start;

  wire        srst   = ctrl_r[`AFMD_CTRL_SRST];
  wire        is_d1  = ctrl_r[`AFMD_CTRL_ISD1];
  wire        d1_pres = ctrl_r[`AFMD_CTRL_D1PRES];
  wire        sel_ok = (drive_head_select_r[`AFMD_DH_DEVSEL] == is_d1);

  // --------------------------------
  // Sub-blocks
  // --------------------------------
  afmd_selftest u_selftest (
    .clock    (clock),
    .reset    (reset | srst),
    .start    (st_start),
    .buf_fail (ctrl_r[`AFMD_CTRL_BUFERR]),
    .rom_fail (ctrl_r[`AFMD_CTRL_ROMERR]),
    .done     (st_done),
    .code     (st_code)
  );

  afmd_decode u_decode (
    .count     (count_reg_r),
    .xfer_ok   (xfer_ok),
    .aam_class (aam_class)
  );

  // --------------------------------
  // Bus handshakes
  // --------------------------------
  wire        wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire        rd_go = s_axi_arvalid & ~s_axi_rvalid;
  wire [11:0] wr_ix = s_axi_awaddr[13:2];
  wire [11:0] rd_ix = s_axi_araddr[13:2];
  wire [7:0]  wb    = s_axi_wdata[7:0];
  wire        wl0   = wr_go & s_axi_wstrb[0];

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  // PDIAG- is open drain: only ever pulled low
  assign pdiag_n_out  = 1'b0;
  assign pdiag_n_oe_n = ~pdiag_drive_r;

  // Task file is frozen while busy, as a real drive would ignore it
  wire tf_wr     = wl0 & ~bsy_r;
  wire cmd_wr    = tf_wr & (wr_ix == `AFMD_IX_CMD);
  wire cmd_take  = cmd_wr & (sel_ok | (wb == `AFMD_OP_DIAG)); // R18
  wire stat_rd   = rd_go & (rd_ix == `AFMD_IX_CMD) & sel_ok;

  // --------------------------------
  // Identify words
  // --------------------------------
  wire [15:0] id47 = `AFMD_ID47; // R16
  wire [15:0] id59 = mult_en_r ? {`AFMD_ID59_EN, mult_cnt_r} : 16'h0000; // R17
  wire [15:0] id86 = {6'h00, aam_en_r, 9'h000}; // R10
  wire [15:0] id94 = {8'h00, aam_en_r ? aam_level_r : 8'h00}; // R10
  wire [7:0]  status = {bsy_r, ~bsy_r, 5'h08, err_r & ~bsy_r};

  // Supported block counts: exactly one bit set among 2, 4, 8, 16
  wire cnt_ok = (count_reg_r == 8'h02) | (count_reg_r == 8'h04) |
                (count_reg_r == 8'h08) | (count_reg_r == 8'h10); // R11

  // --------------------------------
  // Feature subcode acceptance
  // --------------------------------
  reg sub_ok;
  always @* begin
    case (subcode_reg_r)
      `AFMD_SUB_XFER:   sub_ok = xfer_ok; // R1 R2 R3 R4 R5
      `AFMD_SUB_AAM_ON: sub_ok = 1'b1;
      `AFMD_SUB_AAM_OFF: sub_ok = 1'b1;
      8'h02, 8'h04, 8'h05, 8'h33, 8'h54, 8'h55, 8'h66, 8'h77, 8'h81,
      8'h82, 8'h84, 8'h85, 8'h88, 8'h89, 8'hAA, 8'hAB, 8'hBB, 8'hCC:
        sub_ok = 1'b1;
      default:          sub_ok = 1'b0; // R23
    endcase
  end

  // --------------------------------
  // Acoustic state (no reset term)
  // --------------------------------
  always @(posedge clock) begin
    if (state_r == S_EXEC && opcode_reg_r == `AFMD_OP_FEAT) begin
      if (subcode_reg_r == `AFMD_SUB_AAM_ON) begin
        aam_en_r    <= 1'b1; // R7 R9
        aam_level_r <= count_reg_r;
      end else if (subcode_reg_r == `AFMD_SUB_AAM_OFF) begin
        aam_en_r    <= 1'b0; // R10
      end
    end
  end

  // --------------------------------
  // Multiple mode: hard reset clears, soft reset keeps
  // --------------------------------
  always @(posedge clock) begin
    if (reset) begin
      mult_en_r  <= 1'b0; // R15
      mult_cnt_r <= 8'h00;
    end else if (state_r == S_EXEC && opcode_reg_r == `AFMD_OP_MULT) begin
      mult_en_r  <= cnt_ok; // R12 R13
      if (cnt_ok)
        mult_cnt_r <= count_reg_r;
    end
  end

  // --------------------------------
  // Command sequencer and task file
  // --------------------------------
  always @(posedge clock) begin
    if (reset) begin
      state_r             <= S_IDLE;
      opcode_reg_r        <= 8'h00;
      subcode_reg_r       <= 8'h00;
      count_reg_r         <= 8'h00;
      sector_index_reg_r  <= 8'h00;
      cyl_low_r           <= 8'h00;
      cyl_high_r          <= 8'h00;
      drive_head_select_r <= 8'h00;
      fault_code_reg_r    <= `AFMD_DG_OK;
      bsy_r               <= 1'b0;
      err_r               <= 1'b0;
      intrq               <= 1'b0;
      xfer_mode_r         <= `AFMD_XFER_RST; // R6
      pdiag_drive_r       <= 1'b0;
      wait_r              <= 32'h0;
      diag_code_r         <= `AFMD_DG_OK;
      st_start            <= 1'b0;
    end else if (srst) begin
      // Soft reset ends any command but keeps settings
      state_r       <= S_IDLE;
      bsy_r         <= 1'b0;
      err_r         <= 1'b0;
      intrq         <= 1'b0;
      pdiag_drive_r <= 1'b0;
      st_start      <= 1'b0;
    end else begin
      st_start <= 1'b0;
      if (stat_rd)
        intrq <= 1'b0;
      if (tf_wr) begin
        case (wr_ix)
          `AFMD_IX_FEAT:  subcode_reg_r       <= wb;
          `AFMD_IX_COUNT: count_reg_r         <= wb;
          `AFMD_IX_SECT:  sector_index_reg_r  <= wb;
          `AFMD_IX_CYLLO: cyl_low_r           <= wb;
          `AFMD_IX_CYLHI: cyl_high_r          <= wb;
          `AFMD_IX_DRVHD: drive_head_select_r <= wb;
          default: ;
        endcase
      end
      case (state_r)
        S_IDLE: begin
          if (cmd_take) begin
            opcode_reg_r <= wb;
            bsy_r        <= 1'b1; // R12 R23
            err_r        <= 1'b0;
            if (wb == `AFMD_OP_DIAG) begin
              state_r       <= S_DIAG; // R18
              st_start      <= 1'b1;
              pdiag_drive_r <= 1'b0;
            end else begin
              state_r <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          state_r <= S_IDLE;
          bsy_r   <= 1'b0; // R14 R23
          intrq   <= 1'b1;
          case (opcode_reg_r)
            `AFMD_OP_FEAT: begin
              err_r <= ~sub_ok; // R23
              if (subcode_reg_r == `AFMD_SUB_XFER && xfer_ok)
                xfer_mode_r <= count_reg_r;
            end
            `AFMD_OP_MULT: err_r <= ~cnt_ok & (count_reg_r != 8'h00); // R13
            default:       err_r <= 1'b1;
          endcase
          fault_code_reg_r <= `AFMD_ERR_ABRT;
        end
        S_DIAG: begin
          if (st_done) begin
            diag_code_r <= st_code;
            wait_r      <= 32'h0;
            if (is_d1) begin
              pdiag_drive_r <= (st_code == `AFMD_DG_OK);
              state_r       <= S_IDLE;
              bsy_r         <= 1'b0; // R21
              fault_code_reg_r <= st_code;
            end else if (d1_pres) begin
              state_r <= S_WAIT; // R19
            end else begin
              state_r          <= S_IDLE;
              bsy_r            <= 1'b0;
              intrq            <= 1'b1; // R21
              fault_code_reg_r <= st_code; // R24
            end
          end
        end
        S_WAIT: begin
          wait_r <= wait_r + 32'h1;
          if (~pdiag_n_in) begin
            state_r          <= S_IDLE;
            bsy_r            <= 1'b0;
            intrq            <= 1'b1; // R21
            fault_code_reg_r <= diag_code_r; // R24
          end else if (wait_r >= D1_WAIT_CYC - 32'h1) begin
            state_r          <= S_IDLE; // R19
            bsy_r            <= 1'b0;
            intrq            <= 1'b1;
            fault_code_reg_r <= diag_code_r | `AFMD_DG_D1FAIL; // R20
          end
        end
        default: state_r <= S_IDLE;
      endcase
      // Diagnostic completion leaves the signature in the task file
      if ((state_r == S_DIAG && st_done && (is_d1 | ~d1_pres)) ||
          (state_r == S_WAIT && (~pdiag_n_in || wait_r >= D1_WAIT_CYC - 32'h1))) begin
        count_reg_r         <= `AFMD_DG_ONE;
        sector_index_reg_r  <= `AFMD_DG_ONE;
        cyl_low_r           <= 8'h00;
        cyl_high_r          <= 8'h00;
        drive_head_select_r <= 8'h00;
      end
    end
  end

  // --------------------------------
  // Control register (written any time, even while busy)
  // --------------------------------
  always @(posedge clock) begin
    if (reset)
      ctrl_r <= 5'h00;
    else if (wl0 && wr_ix == `AFMD_IX_CTRL)
      ctrl_r <= wb[4:0];
  end

  // --------------------------------
  // Write response
  // --------------------------------
  wire wr_mapped = (wr_ix >= `AFMD_IX_FEAT && wr_ix <= `AFMD_IX_CMD) ||
                   (wr_ix == `AFMD_IX_CTRL);

  always @(posedge clock) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AFMD_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `AFMD_RESP_OK : `AFMD_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------
  // Read data
  // --------------------------------
  reg [31:0] rd_mux;
  reg        rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (rd_ix)
      `AFMD_IX_FEAT:    rd_mux = {24'h0, fault_code_reg_r};
      `AFMD_IX_COUNT:   rd_mux = {24'h0, count_reg_r};
      `AFMD_IX_SECT:    rd_mux = {24'h0, sector_index_reg_r};
      `AFMD_IX_CYLLO:   rd_mux = {24'h0, cyl_low_r};
      `AFMD_IX_CYLHI:   rd_mux = {24'h0, cyl_high_r};
      `AFMD_IX_DRVHD:   rd_mux = {24'h0, drive_head_select_r};
      `AFMD_IX_CMD:     rd_mux = {24'h0, status};
      `AFMD_IX_CTRL:    rd_mux = {27'h0, ctrl_r};
      `AFMD_IX_ID47_59: rd_mux = {id59, id47};
      `AFMD_IX_ID86_94: rd_mux = {id94, id86};
      `AFMD_IX_MODE:    rd_mux = {4'h0, state_r, aam_class, xfer_mode_r, // R8
                                  7'h00, mult_en_r, mult_cnt_r};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `AFMD_RESP_OK;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `AFMD_RESP_OK : `AFMD_RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // afmd_top

//--- core/afmd_map.vh
// Register map, opcodes, codes and timing constants of the feature/diagnostic block
`ifndef AFMD_MAP_VH
`define AFMD_MAP_VH

// --------------------------------
// Register indices (byte address = 4 x index)
// --------------------------------
`define AFMD_IX_FEAT     12'h1F1
`define AFMD_IX_COUNT    12'h1F2
`define AFMD_IX_SECT     12'h1F3
`define AFMD_IX_CYLLO    12'h1F4
`define AFMD_IX_CYLHI    12'h1F5
`define AFMD_IX_DRVHD    12'h1F6
`define AFMD_IX_CMD      12'h1F7
`define AFMD_IX_CTRL     12'h200
`define AFMD_IX_ID47_59  12'h201
`define AFMD_IX_ID86_94  12'h202
`define AFMD_IX_MODE     12'h203

// --------------------------------
// Control register bits and drive/head select bit
// --------------------------------
`define AFMD_CTRL_SRST   0
`define AFMD_CTRL_BUFERR 1
`define AFMD_CTRL_ROMERR 2
`define AFMD_CTRL_D1PRES 3
`define AFMD_CTRL_ISD1   4
`define AFMD_DH_DEVSEL   4

// --------------------------------
// Opcodes and feature subcodes
// --------------------------------
`define AFMD_OP_FEAT     8'hEF
`define AFMD_OP_MULT     8'hC6
`define AFMD_OP_DIAG     8'h90
`define AFMD_SUB_XFER    8'h03
`define AFMD_SUB_AAM_ON  8'h42
`define AFMD_SUB_AAM_OFF 8'hC2

// --------------------------------
// Transfer mode encodings
// --------------------------------
`define AFMD_XT_PIODEF   5'h00
`define AFMD_XT_PIOFC    5'h01
`define AFMD_XT_MWDMA    5'h04
`define AFMD_XT_UDMA     5'h08
`define AFMD_XM_PIOMAX   3'h4
`define AFMD_XM_MWMAX    3'h2
`define AFMD_XM_UDMAX    3'h5
`define AFMD_XFER_RST    8'h0C

// --------------------------------
// Acoustic levels, identify words, status and codes
// --------------------------------
`define AFMD_AAM_RSVD    8'hFF
`define AFMD_AAM_PERF    8'hC0
`define AFMD_AAM_QUIET   8'h80
`define AFMD_ID47        16'h8010
`define AFMD_ID59_EN     8'h01
`define AFMD_ID86_AAM    9
`define AFMD_ERR_ABRT    8'h04
`define AFMD_DG_OK       8'h01
`define AFMD_DG_BUF      8'h03
`define AFMD_DG_ROM      8'h05
`define AFMD_DG_D1FAIL   8'h80
`define AFMD_DG_ONE      8'h01
`define AFMD_ST_IDLE     8'h50
`define AFMD_ST_BSY      7
`define AFMD_ST_RDY      6
`define AFMD_ST_ERR      0
`define AFMD_RESP_OK     2'h0
`define AFMD_RESP_ERR    2'h2

// --------------------------------
// Timing
// --------------------------------
`define AFMD_CLK_HZ      100000000
`define AFMD_D1_WAIT_S   5
`define AFMD_SELFTEST_CY 8'h10

`endif

//--- core/afmd_selftest.v
// Self-test sequencer producing the local diagnostic code
`timescale 1ns/1ns
`include "afmd_map.vh"

module afmd_selftest (
  input  wire       clock,
  input  wire       reset,
  input  wire       start,
  input  wire       buf_fail,
  input  wire       rom_fail,
  output reg        done,
  output reg  [7:0] code
);

  reg [7:0] cnt_r;
  reg       run_r;

  always @(posedge clock) begin
    if (reset) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
      done  <= 1'b0;
      code  <= `AFMD_DG_OK;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= 8'h00;
        run_r <= 1'b1;
      end else if (run_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == `AFMD_SELFTEST_CY - 8'h01) begin
          run_r <= 1'b0;
          done  <= 1'b1;
          // Buffer fault outranks ROM fault
          code  <= buf_fail ? `AFMD_DG_BUF : (rom_fail ? `AFMD_DG_ROM : `AFMD_DG_OK);
        end
      end
    end
  end

endmodule // afmd_selftest

//--- core/afmd_decode.v
// Transfer-mode and acoustic-level decoding
`timescale 1ns/1ns
`include "afmd_map.vh"

module afmd_decode (
  input  wire [7:0] count,
  output reg        xfer_ok,
  output reg  [1:0] aam_class
);

  always @* begin
    case (count[7:3])
      `AFMD_XT_PIODEF: xfer_ok = (count[2:0] == 3'h0);
      `AFMD_XT_PIOFC:  xfer_ok = (count[2:0] <= `AFMD_XM_PIOMAX);
      `AFMD_XT_MWDMA:  xfer_ok = (count[2:0] <= `AFMD_XM_MWMAX);
      `AFMD_XT_UDMA:   xfer_ok = (count[2:0] <= `AFMD_XM_UDMAX);
      default:         xfer_ok = 1'b0;
    endcase
    // 3 reserved, 2 max performance, 1 min noise, 0 retired or vendor
    if (count == `AFMD_AAM_RSVD)
      aam_class = 2'h3;
    else if (count >= `AFMD_AAM_PERF)
      aam_class = 2'h2;
    else if (count >= `AFMD_AAM_QUIET)
      aam_class = 2'h1;
    else
      aam_class = 2'h0;
  end

endmodule // afmd_decode

//--- verification/afmd_sva.sv
// Bus and interrupt timing checks for the command block
`timescale 1ns/1ns

module afmd_chk (
  input wire clock,
  input wire reset,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire pdiag_n_oe_n,
  input wire intrq
);
  chk_b_follows: assert property (@(posedge clock) disable iff (reset)
    s_axi_awvalid && s_axi_awready |=> s_axi_bvalid) else $error("write without response");
  chk_r_follows: assert property (@(posedge clock) disable iff (reset)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read without response");
  chk_b_holds: assert property (@(posedge clock) disable iff (reset)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
  chk_r_holds: assert property (@(posedge clock) disable iff (reset)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("read response dropped");
  chk_aw_w_pair: assert property (@(posedge clock) disable iff (reset)
    s_axi_awready == s_axi_wready) else $error("address and data ready differ");
  chk_no_spur_b: assert property (@(posedge clock) disable iff (reset)
    !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready) |=> !s_axi_bvalid)
    else $error("response without write");
  // Interrupt may only fall around a bus access, never on its own
  chk_irq_holds: assert property (@(posedge clock) disable iff (reset)
    intrq && !s_axi_arvalid && !s_axi_awvalid && !$past(s_axi_arvalid)
    && !$past(s_axi_awvalid) |=> intrq) else $error("interrupt lost while bus idle");
  chk_reset_quiet: assert property (@(posedge clock)
    reset |=> !intrq && !s_axi_bvalid && !s_axi_rvalid && pdiag_n_oe_n)
    else $error("outputs active after reset");
endmodule // afmd_chk

//--- verification/afmd_dev1_model.sv
// Second drive on the cable: answers the diagnostic handshake after a set lag
`timescale 1ns/1ns

module afmd_dev1_model (
  input  wire       clock,
  input  wire       reset,
  input  wire       start,
  input  wire [7:0] lag,
  output reg        pull
);
  reg [7:0] cnt_r;

  // Lag of zero models a failed drive that never answers
  always @(posedge clock) begin
    if (reset || start) begin
      cnt_r <= reset ? 8'h00 : lag;
      pull  <= 1'b0;
    end else if (cnt_r > 8'h01) begin
      cnt_r <= cnt_r - 8'h01;
    end else if (cnt_r == 8'h01) begin
      cnt_r <= 8'h00;
      pull  <= 1'b1;
    end
  end
endmodule // afmd_dev1_model

//--- verification/afmd_top_tb_top.sv
// Self-checking bench of the feature, block-count and diagnostic command block
`timescale 1ns/1ns
`include "afmd_map.vh"

module afmd_top_tb_top;
  reg         clock = 1'b0;
  reg         reset = 1'b1;
  reg  [13:0] awaddr = 14'h0000;
  reg  [31:0] wdata = 32'h00000000;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg  [13:0] araddr = 14'h0000;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg         d1_go = 1'b0;
  reg  [7:0]  d1_lag = 8'h00;
  wire        awready, wready, bvalid, arready, rvalid, intrq, oe_n, d1_pull, pd_out;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  reg  [31:0] rv;
  reg  [1:0]  rr;
  reg  [7:0]  sts;
  integer     nw;
  integer     err_total = 0;
  integer     cmp_count = 0;
  wire        pdiag_n = (oe_n | pd_out) & ~d1_pull;

  always #5 clock = ~clock;

  afmd_top #(.D1_WAIT_CYC(32'd50)) uut (
    .clock(clock), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pdiag_n_in(pdiag_n), .pdiag_n_out(pd_out), .pdiag_n_oe_n(oe_n), .intrq(intrq));

  afmd_dev1_model u_dev1 (.clock(clock), .reset(reset), .start(d1_go), .lag(d1_lag),
    .pull(d1_pull));

  // --------------------------------
  // Bus cycles and shared helpers
  // --------------------------------
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [11:0] ix, input [7:0] d);
    begin
      @(posedge clock);
      awaddr  <= {ix, 2'b00};
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do @(posedge clock); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do @(posedge clock); while (bvalid !== 1'b1);
      chk(bresp, `AFMD_RESP_OK);
      bready  <= 1'b0;
    end
  endtask

  task rd(input [11:0] ix);
    begin
      @(posedge clock);
      araddr  <= {ix, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clock); while (rvalid !== 1'b1);
      rv = rdata;
      rr = rresp;
      rready  <= 1'b0;
    end
  endtask

  // Status read must clear the interrupt
  task cmd(input [7:0] op);
    begin
      wr(`AFMD_IX_CMD, op);
      nw = 0;
      while (intrq !== 1'b1 && nw < 300) begin
        @(posedge clock);
        nw = nw + 1;
      end
      chk(intrq, 1'b1);
      rd(`AFMD_IX_CMD);
      sts = rv[7:0];
      @(posedge clock);
      chk(sts[7], 1'b0);
      chk(intrq, 1'b0);
    end
  endtask

  task feat(input [7:0] sub, input [7:0] cnt);
    begin
      wr(`AFMD_IX_FEAT, sub);
      wr(`AFMD_IX_COUNT, cnt);
      cmd(`AFMD_OP_FEAT);
    end
  endtask

  task hard_rst;
    begin
      @(posedge clock);
      reset <= 1'b1;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
    end
  endtask

  task soft_rst;
    begin
      wr(`AFMD_IX_CTRL, 8'h01);
      wr(`AFMD_IX_CTRL, 8'h00);
    end
  endtask

  function ok_x(input [7:0] v);
    ok_x = v == 8'h00 || (v >= 8'h08 && v <= 8'h0C) || (v >= 8'h20 && v <= 8'h22)
      || (v >= 8'h40 && v <= 8'h45);
  endfunction

  // --------------------------------
  // Scenarios
  // --------------------------------
  task t_reset_view;
    begin
      rd(`AFMD_IX_CMD);
      chk(rv[7:0], `AFMD_ST_IDLE);
      rd(`AFMD_IX_ID47_59);
      chk(rv, 32'h00008010);
      rd(`AFMD_IX_MODE);
      chk(rv[23:16], 8'h0C);
      rd(12'h100);
      chk(rr, 2'h2);
      chk(rv, 32'h00000000);
    end
  endtask

  // Every count value, so each accepted mode and each gap is hit
  task t_xfer;
    integer   v;
    reg [7:0] xm;
    begin
      xm = 8'h0C;
      for (v = 0; v < 256; v = v + 1) begin
        feat(`AFMD_SUB_XFER, v[7:0]);
        chk(sts[0], !ok_x(v[7:0]));
        if (ok_x(v[7:0])) xm = v[7:0];
        rd(`AFMD_IX_MODE);
        chk(rv[23:16], xm);
        rd(`AFMD_IX_FEAT);
        if (sts[0]) chk(rv[7:0], `AFMD_ERR_ABRT);
      end
      feat(8'h01, 8'h00);
      chk(sts[0], 1'b1);
      feat(8'h02, 8'h00);
      chk(sts[0], 1'b0);
    end
  endtask

  task t_aam;
    integer   i;
    reg [7:0] l;
    reg [1:0] c;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        l = 64'hFF_C0_FE_80_BF_01_00_7F >> (8 * i);
        c = l == 8'hFF ? 2'h3 : l >= 8'hC0 ? 2'h2 : l >= 8'h80 ? 2'h1 : 2'h0;
        feat(`AFMD_SUB_AAM_ON, l);
        rd(`AFMD_IX_ID86_94);
        chk({rv[23:16], rv[9]}, {l, 1'b1});
        rd(`AFMD_IX_MODE);
        chk(rv[25:24], c);
      end
      hard_rst;
      soft_rst;
      rd(`AFMD_IX_ID86_94);
      chk({rv[23:16], rv[9]}, 9'h0FF);
      feat(`AFMD_SUB_AAM_OFF, 8'h00);
      rd(`AFMD_IX_ID86_94);
      chk({sts[0], rv[23:16], rv[9]}, 10'h000);
      hard_rst;
      rd(`AFMD_IX_ID86_94);
      chk({rv[23:16], rv[9]}, 9'h000);
    end
  endtask

  task t_mult;
    integer   i;
    reg [7:0] c;
    reg       ok;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        c  = 64'h02_04_08_10_00_03_01_20 >> (8 * i);
        ok = c == 8'h02 || c == 8'h04 || c == 8'h08 || c == 8'h10;
        wr(`AFMD_IX_COUNT, c);
        cmd(`AFMD_OP_MULT);
        chk(sts[0], !(ok || c == 8'h00));
        rd(`AFMD_IX_ID47_59);
        chk(rv[31:16], ok ? {8'h01, c} : 16'h0000);
        rd(`AFMD_IX_MODE);
        chk(rv[8], ok);
      end
      wr(`AFMD_IX_COUNT, 8'h10);
      cmd(`AFMD_OP_MULT);
      soft_rst;
      rd(`AFMD_IX_ID47_59);
      chk(rv[31:16], 16'h0110);
      hard_rst;
      rd(`AFMD_IX_ID47_59);
      chk(rv[31:16], 16'h0000);
    end
  endtask

  // Select bit set on device 0 on purpose: the diagnostic must still run
  task t_diag;
    integer   i;
    reg [7:0] c;
    reg [7:0] e;
    begin
      for (i = 6; i >= 0; i = i - 1) begin
        c = 56'h00_02_04_06_08_08_0A >> (8 * i);
        e = 56'h01_03_05_03_01_81_83 >> (8 * i);
        wr(`AFMD_IX_CTRL, c);
        wr(`AFMD_IX_DRVHD, 8'h10);
        d1_lag <= (i == 2) ? 8'h28 : 8'h00;
        @(posedge clock);
        d1_go <= 1'b1;
        @(posedge clock);
        d1_go <= 1'b0;
        cmd(`AFMD_OP_DIAG);
        if (c[3] && i != 2) chk(nw >= 45 && nw <= 80, 1'b1);
        rd(`AFMD_IX_FEAT);
        chk(rv[7:0], e);
        rd(`AFMD_IX_COUNT);
        chk(rv[7:0], 8'h01);
      end
      wr(`AFMD_IX_CTRL, 8'h00);
    end
  endtask

  task t_dev1;
    integer n;
    reg     seen;
    begin
      wr(`AFMD_IX_CTRL, 8'h10);
      wr(`AFMD_IX_DRVHD, 8'h10);
      wr(`AFMD_IX_CMD, `AFMD_OP_DIAG);
      seen = 1'b0;
      for (n = 0; n < 150; n = n + 1) begin
        @(posedge clock);
        seen = seen | (intrq === 1'b1);
      end
      chk(oe_n, 1'b0);
      chk(seen, 1'b0);
      wr(`AFMD_IX_DRVHD, 8'h10);
      rd(`AFMD_IX_CMD);
      chk(rv[7:0], `AFMD_ST_IDLE);
      hard_rst;
    end
  endtask

  task stop_test;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  initial begin
    hard_rst;
    t_reset_view;
    t_xfer;
    t_aam;
    t_mult;
    t_diag;
    t_dev1;
    stop_test;
  end

  initial begin
    #900000;
    err_total = err_total + 1;
    stop_test;
  end
endmodule // afmd_top_tb_top

bind afmd_top afmd_chk u_chk (.clock(clock), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pdiag_n_oe_n(pdiag_n_oe_n), .intrq(intrq));
